// ### rtl/cct_pkg.sv
// Package with register map, field positions and reset values of the capture/compare timer
package cct_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE_ONE = 8'h0c;
  localparam logic [7:0] ADDR_CAPTURE_TWO = 8'h10;
  localparam logic [7:0] ADDR_COMPARE_ONE = 8'h14;
  localparam logic [7:0] ADDR_COMPARE_TWO = 8'h18;
  localparam logic [7:0] ADDR_COUNTER = 8'h1c;
  localparam logic [7:0] ADDR_ALT_COUNTER = 8'h20;

  // Control register one fields
  localparam int C1_CAPTURE_IRQ_ENABLE = 7;
  localparam int C1_COMPARE_IRQ_ENABLE = 6;
  localparam int C1_OVERFLOW_IRQ_ENABLE = 5;
  localparam int C1_FORCE_OUT_TWO = 4;
  localparam int C1_FORCE_OUT_ONE = 3;
  localparam int C1_LEVEL_TWO = 2;
  localparam int C1_CAPTURE_ONE_EDGE = 1;
  localparam int C1_LEVEL_ONE = 0;

  // Control register two fields
  localparam int C2_COMPARE_PIN_ONE_ENABLE = 7;
  localparam int C2_COMPARE_PIN_TWO_ENABLE = 6;
  localparam int C2_ONE_PULSE_SELECT = 5;
  localparam int C2_PWM_SELECT = 4;
  localparam int C2_CLOCK_SELECT_HI = 3;
  localparam int C2_CLOCK_SELECT_LO = 2;
  localparam int C2_CAPTURE_TWO_EDGE = 1;
  localparam int C2_EXT_CLOCK_EDGE = 0;

  // Status register fields
  localparam int ST_CAPTURE_ONE_FLAG = 7;
  localparam int ST_COMPARE_ONE_FLAG = 6;
  localparam int ST_OVERFLOW_FLAG = 5;
  localparam int ST_CAPTURE_TWO_FLAG = 4;
  localparam int ST_COMPARE_TWO_FLAG = 3;
  localparam int ST_TIMER_DISABLE = 2;

  // Clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;

  // Reset and reload values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'hfffc;
  localparam logic [15:0] COUNTER_TOP = 16'hffff;
  localparam logic [15:0] PULSE_CAPTURE_VALUE = 16'hfffd;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
endpackage

// ### rtl/cct_timer.sv
// Capture/compare timer with control registers, low-power handling and APB slave
//
// Notes on behaviour
// - Wait mode leaves timer running; enabled interrupts wake the device.
// - Halt freezes counter and registers; interrupt wake resumes, reset restarts.
// - Capture edge in halt arms; interrupt exit sets flag, captures count.
// - PWM period end sets capture flag one; no compare flags in PWM.
// - One shared request line, gated by enables and global interrupt mask.
// - Capture enable bit 7 requests on either capture flag.
// - Compare enable bit 6 requests on either compare flag.
// - Overflow enable bit 5 requests on the overflow flag.
// - Force bit 4 puts level two on compare pin two when enabled.
// - Force bit 3 puts level one on compare pin one when enabled.
// - Level two driven on compare-two match; pin one in pulse modes.
// - Control one bit 1 picks capture-one edge: 0 falling, 1 rising.
// - Level one driven onto compare pin one on compare-one match.
// - Control two bit 7 only enables compare pin one output.
// - Control two bit 6 only enables compare pin two output.
// - Bit 5 one-pulse mode: capture-one edge starts pulse, length compare one.
// - Bit 4 PWM: pulse length compare one, period compare two.
// - Clock field: 00 div4, 01 div2, 10 div8, 11 external clock.
// - External clock selected without pin stops the counter.
// - Control two bit 1 picks capture-two edge: 0 falling, 1 rising.
// - Control two bit 0 picks external clock edge: 0 falling, 1 rising.
// - Flag clears after status read then access to its data register.
// - Overflow flag set when counter wraps from ffff to 0000.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module cct_timer #(
  parameter bit HAS_EXT_CLOCK_PIN = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic halt_i,
  input wire logic global_irq_mask_i,
  input wire logic capture_pin_one_i,
  input wire logic capture_pin_two_i,
  input wire logic ext_clock_pin_i,
  output logic compare_pin_one_o,
  output logic compare_pin_one_oe_n_o,
  output logic compare_pin_two_o,
  output logic compare_pin_two_oe_n_o,
  output logic timer_irq_o
);
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic timer_disable_reg;
  logic [4:0] flags_reg;
  logic [4:0] clear_armed_reg;
  logic [15:0] counter_reg;
  logic [15:0] capture_one_reg;
  logic [15:0] capture_two_reg;
  logic [15:0] compare_one_reg;
  logic [15:0] compare_two_reg;
  logic [15:0] active_one_reg;
  logic [15:0] active_two_reg;
  logic [2:0] prescale_reg;
  logic [2:0] cap_one_sync_reg;
  logic [2:0] cap_two_sync_reg;
  logic [2:0] ext_sync_reg;
  logic [1:0] halt_armed_reg;
  logic halt_d_reg;
  logic pin_one_reg;
  logic pin_two_reg;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic irq_reg;

  // Flag vector order
  localparam int F_CAP1 = 4;
  localparam int F_CMP1 = 3;
  localparam int F_OVF = 2;
  localparam int F_CAP2 = 1;
  localparam int F_CMP2 = 0;

  logic access;
  logic wr;
  logic rd;
  logic mode_pwm;
  logic mode_opm;
  logic frozen;
  logic tick;
  logic [1:0] clock_sel;
  logic edge_one;
  logic edge_two;
  logic rise_one;
  logic fall_one;
  logic rise_two;
  logic fall_two;
  logic ext_rise;
  logic ext_fall;
  logic halt_exit;
  logic match_one;
  logic match_two;
  logic wrap;
  logic pulse_start;
  logic counter_write;
  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  logic [15:0] cmp_one_use;
  logic [15:0] cmp_two_use;

  // Access is taken on the second access cycle, when ready is high
  assign access = psel_i & penable_i & ready_reg;
  assign wr = access & pwrite_i;
  assign rd = access & ~pwrite_i;

  // PWM takes precedence when both pulse modes are set
  assign mode_pwm = ctrl_two_reg[cct_pkg::C2_PWM_SELECT];
  assign mode_opm = ctrl_two_reg[cct_pkg::C2_ONE_PULSE_SELECT] & ~mode_pwm;
  assign frozen = halt_i | timer_disable_reg;
  assign clock_sel = ctrl_two_reg[cct_pkg::C2_CLOCK_SELECT_HI:cct_pkg::C2_CLOCK_SELECT_LO];

  assign rise_one = cap_one_sync_reg[1] & ~cap_one_sync_reg[2];
  assign fall_one = ~cap_one_sync_reg[1] & cap_one_sync_reg[2];
  assign rise_two = cap_two_sync_reg[1] & ~cap_two_sync_reg[2];
  assign fall_two = ~cap_two_sync_reg[1] & cap_two_sync_reg[2];
  assign ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
  assign ext_fall = ~ext_sync_reg[1] & ext_sync_reg[2];

  assign edge_one = ctrl_one_reg[cct_pkg::C1_CAPTURE_ONE_EDGE] ? rise_one : fall_one;
  assign edge_two = ctrl_two_reg[cct_pkg::C2_CAPTURE_TWO_EDGE] ? rise_two : fall_two;

  always_comb begin
    case (clock_sel)
      cct_pkg::CLK_DIV2: tick = prescale_reg[0];
      cct_pkg::CLK_DIV4: tick = &prescale_reg[1:0];
      cct_pkg::CLK_DIV8: tick = &prescale_reg;
      // external edge choice, no pin means no tick
      default: tick = HAS_EXT_CLOCK_PIN &
          (ctrl_two_reg[cct_pkg::C2_EXT_CLOCK_EDGE] ? ext_rise : ext_fall);
    endcase
    tick = tick & ~frozen;
  end

  // In PWM the buffered copies compare, elsewhere the live values
  assign cmp_one_use = mode_pwm ? active_one_reg : compare_one_reg;
  assign cmp_two_use = mode_pwm ? active_two_reg : compare_two_reg;
  assign match_one = tick & (counter_reg == cmp_one_use);
  assign match_two = tick & (counter_reg == cmp_two_use);
  assign wrap = tick & (counter_reg == cct_pkg::COUNTER_TOP) & ~(mode_pwm & match_two);
  // One-pulse trigger is ignored while halted
  assign pulse_start = mode_opm & edge_one & ~frozen;
  assign halt_exit = halt_d_reg & ~halt_i;
  assign counter_write = wr &
      (paddr_i == cct_pkg::ADDR_COUNTER || paddr_i == cct_pkg::ADDR_ALT_COUNTER);

  // Hardware flag sources
  always_comb begin
    set_vec = '0;
    // captures on halt exit, PWM period end
    set_vec[F_CAP1] = (edge_one & ~frozen & ~mode_pwm) | (halt_exit & halt_armed_reg[0])
        | (mode_pwm & match_two);
    set_vec[F_CAP2] = (edge_two & ~frozen) | (halt_exit & halt_armed_reg[1]);
    // no compare flags in PWM; compare one also silent in one-pulse
    set_vec[F_CMP1] = match_one & ~mode_pwm & ~mode_opm;
    set_vec[F_CMP2] = match_two & ~mode_pwm;
    set_vec[F_OVF] = wrap;
  end

  always_comb begin
    clr_vec = '0;
    if (access) begin
      clr_vec[F_CAP1] = paddr_i == cct_pkg::ADDR_CAPTURE_ONE;
      clr_vec[F_CAP2] = paddr_i == cct_pkg::ADDR_CAPTURE_TWO;
      clr_vec[F_CMP1] = paddr_i == cct_pkg::ADDR_COMPARE_ONE;
      clr_vec[F_CMP2] = paddr_i == cct_pkg::ADDR_COMPARE_TWO;
      // Alternate counter deliberately does not clear overflow
      clr_vec[F_OVF] = paddr_i == cct_pkg::ADDR_COUNTER;
    end
    clr_vec = clr_vec & clear_armed_reg;
  end

  // Setting wins over a simultaneous clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clear_armed_reg <= '0;
    end else if (rd && paddr_i == cct_pkg::ADDR_STATUS) begin
      clear_armed_reg <= flags_reg;
    end else begin
      clear_armed_reg <= clear_armed_reg & ~clr_vec;
    end
  end

  // Pin synchronisers, third stage only for edge detection
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_one_sync_reg <= '0;
      cap_two_sync_reg <= '0;
      ext_sync_reg <= '0;
      halt_d_reg <= 1'b0;
    end else begin
      cap_one_sync_reg <= {cap_one_sync_reg[1:0], capture_pin_one_i};
      cap_two_sync_reg <= {cap_two_sync_reg[1:0], capture_pin_two_i};
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clock_pin_i};
      halt_d_reg <= halt_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_armed_reg <= '0;
    end else if (!halt_i) begin
      halt_armed_reg <= '0;
    end else begin
      halt_armed_reg <= halt_armed_reg | {edge_two, edge_one & ~mode_pwm};
    end
  end

  // Free-running prescaler, stopped while frozen
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale_reg <= '0;
    end else if (!frozen) begin
      prescale_reg <= prescale_reg + 3'h1;
    end
  end

  // Counter; reset wake restarts from reset value via arst
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      counter_reg <= cct_pkg::COUNTER_RESET;
    end else if (counter_write) begin
      counter_reg <= cct_pkg::COUNTER_RESET;
    end else if (pulse_start) begin
      counter_reg <= cct_pkg::COUNTER_RESET;
    end else if (mode_pwm && match_two) begin
      counter_reg <= cct_pkg::COUNTER_RESET;
    // counts in wait, holds in halt
    end else if (tick) begin
      counter_reg <= counter_reg + 16'h0001;
    end
  end

  // Capture registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      capture_one_reg <= cct_pkg::CAPTURE_RESET;
      capture_two_reg <= cct_pkg::CAPTURE_RESET;
    end else begin
      if (pulse_start) begin
        capture_one_reg <= cct_pkg::PULSE_CAPTURE_VALUE;
      end else if ((edge_one && !frozen && !mode_pwm) || (halt_exit && halt_armed_reg[0])) begin
        capture_one_reg <= counter_reg;
      end
      if ((edge_two && !frozen) || (halt_exit && halt_armed_reg[1])) begin
        capture_two_reg <= counter_reg;
      end
    end
  end

  // Compare registers and PWM double buffer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      compare_one_reg <= cct_pkg::COMPARE_RESET;
      compare_two_reg <= cct_pkg::COMPARE_RESET;
      active_one_reg <= cct_pkg::COMPARE_RESET;
      active_two_reg <= cct_pkg::COMPARE_RESET;
    end else begin
      if (wr && paddr_i == cct_pkg::ADDR_COMPARE_ONE) begin
        compare_one_reg <= pwdata_i[15:0];
      end
      if (wr && paddr_i == cct_pkg::ADDR_COMPARE_TWO) begin
        compare_two_reg <= pwdata_i[15:0];
      end
      // In PWM new values take hold only at period end, avoiding glitches
      if (!mode_pwm || match_two) begin
        active_one_reg <= compare_one_reg;
        active_two_reg <= compare_two_reg;
      end
    end
  end

  // Control registers and timer disable
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_one_reg <= cct_pkg::CTRL_RESET;
      ctrl_two_reg <= cct_pkg::CTRL_RESET;
      timer_disable_reg <= 1'b0;
    end else if (wr) begin
      case (paddr_i)
        cct_pkg::ADDR_CTRL_ONE: ctrl_one_reg <= pwdata_i[7:0];
        cct_pkg::ADDR_CTRL_TWO: ctrl_two_reg <= pwdata_i[7:0];
        cct_pkg::ADDR_STATUS: timer_disable_reg <= pwdata_i[cct_pkg::ST_TIMER_DISABLE];
        default: ;
      endcase
    end
  end

  // Compare pin one level
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_one_reg <= 1'b0;
    end else if (mode_pwm || mode_opm) begin
      // level two starts pulse or period
      if (pulse_start || (mode_pwm && match_two)) begin
        pin_one_reg <= ctrl_one_reg[cct_pkg::C1_LEVEL_TWO];
      end else if (match_one) begin
        pin_one_reg <= ctrl_one_reg[cct_pkg::C1_LEVEL_ONE];
      end
    end else if (ctrl_one_reg[cct_pkg::C1_FORCE_OUT_ONE]) begin
      pin_one_reg <= ctrl_one_reg[cct_pkg::C1_LEVEL_ONE];
    end else if (match_one) begin
      pin_one_reg <= ctrl_one_reg[cct_pkg::C1_LEVEL_ONE];
    end
  end

  // Compare pin two level; idle in pulse modes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_two_reg <= 1'b0;
    end else if (!mode_pwm && !mode_opm) begin
      if (ctrl_one_reg[cct_pkg::C1_FORCE_OUT_TWO]) begin
        pin_two_reg <= ctrl_one_reg[cct_pkg::C1_LEVEL_TWO];
      end else if (match_two) begin
        pin_two_reg <= ctrl_one_reg[cct_pkg::C1_LEVEL_TWO];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      compare_pin_one_o <= 1'b0;
      compare_pin_two_o <= 1'b0;
      compare_pin_one_oe_n_o <= 1'b1;
      compare_pin_two_oe_n_o <= 1'b1;
    end else begin
      compare_pin_one_o <= pin_one_reg;
      compare_pin_two_o <= pin_two_reg;
      compare_pin_one_oe_n_o <=
          ~(ctrl_two_reg[cct_pkg::C2_COMPARE_PIN_ONE_ENABLE] & ~timer_disable_reg);
      compare_pin_two_oe_n_o <=
          ~(ctrl_two_reg[cct_pkg::C2_COMPARE_PIN_TWO_ENABLE] & ~timer_disable_reg);
    end
  end

  // one line, masked globally; held as level
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ~global_irq_mask_i & (
          (ctrl_one_reg[cct_pkg::C1_CAPTURE_IRQ_ENABLE] & (flags_reg[F_CAP1] | flags_reg[F_CAP2]))
          | (ctrl_one_reg[cct_pkg::C1_COMPARE_IRQ_ENABLE] & (flags_reg[F_CMP1] | flags_reg[F_CMP2]))
          | (ctrl_one_reg[cct_pkg::C1_OVERFLOW_IRQ_ENABLE] & flags_reg[F_OVF]));
    end
  end
  assign timer_irq_o = irq_reg;

  // Bus answer: one wait state, read data registered with ready
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ready_reg <= psel_i & penable_i & ~ready_reg;
      rdata_reg <= '0;
      if (psel_i && penable_i && !ready_reg && !pwrite_i) begin
        case (paddr_i)
          cct_pkg::ADDR_CTRL_ONE: rdata_reg <= {24'h000000, ctrl_one_reg};
          cct_pkg::ADDR_CTRL_TWO: rdata_reg <= {24'h000000, ctrl_two_reg};
          cct_pkg::ADDR_STATUS: rdata_reg <= {24'h000000, flags_reg, timer_disable_reg, 2'h0};
          cct_pkg::ADDR_CAPTURE_ONE: rdata_reg <= {16'h0000, capture_one_reg};
          cct_pkg::ADDR_CAPTURE_TWO: rdata_reg <= {16'h0000, capture_two_reg};
          cct_pkg::ADDR_COMPARE_ONE: rdata_reg <= {16'h0000, compare_one_reg};
          cct_pkg::ADDR_COMPARE_TWO: rdata_reg <= {16'h0000, compare_two_reg};
          cct_pkg::ADDR_COUNTER: rdata_reg <= {16'h0000, counter_reg};
          cct_pkg::ADDR_ALT_COUNTER: rdata_reg <= {16'h0000, counter_reg};
          default: rdata_reg <= '0;
        endcase
      end
    end
  end
  assign pready_o = ready_reg;
  assign prdata_o = rdata_reg;
  // Unmapped addresses read zero and ignore writes; no error signalled
  assign pslverr_o = 1'b0;
endmodule

// ### sim/cct_timer_chk.sv
// Checker for bus timing, interrupt gating and pin outputs of the timer
`timescale 1ns/10ps
module cct_timer_chk #(
  parameter bit HAS_EXT_CLOCK_PIN = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic halt_i,
  input wire logic global_irq_mask_i,
  input wire logic capture_pin_one_i,
  input wire logic capture_pin_two_i,
  input wire logic ext_clock_pin_i,
  input wire logic compare_pin_one_o,
  input wire logic compare_pin_one_oe_n_o,
  input wire logic compare_pin_two_o,
  input wire logic compare_pin_two_oe_n_o,
  input wire logic timer_irq_o
);
  logic [7:0] c1_reg;
  logic [7:0] c2_reg;
  logic off_reg;
  logic wr_done;
  logic force_one;
  logic force_two;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  // Forcing has no effect in the pulse modes or while disabled
  assign force_one = c1_reg[3] && c2_reg[7] && (c2_reg[5:4] == 2'h0) && !off_reg;
  assign force_two = c1_reg[4] && c2_reg[6] && (c2_reg[5:4] == 2'h0) && !off_reg;

  // Shadow of the control bits, taken from completed writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c1_reg <= cct_pkg::CTRL_RESET;
      c2_reg <= cct_pkg::CTRL_RESET;
      off_reg <= 1'b0;
    end else if (wr_done) begin
      if (paddr_i == cct_pkg::ADDR_CTRL_ONE) c1_reg <= pwdata_i[7:0];
      if (paddr_i == cct_pkg::ADDR_CTRL_TWO) c2_reg <= pwdata_i[7:0];
      if (paddr_i == cct_pkg::ADDR_STATUS) off_reg <= pwdata_i[cct_pkg::ST_TIMER_DISABLE];
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  AST_PREADY_WAIT: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_PREADY_IN_ACCESS: assert property (pready_o |-> s_access)
    else $error("ready outside access phase");
  AST_NO_SLVERR: assert property (!pslverr_o)
    else $error("slave error raised");
  AST_UNMAPPED_ZERO: assert property (pready_o && !pwrite_i
    && paddr_i > cct_pkg::ADDR_ALT_COUNTER |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_ONE_READ: assert property (pready_o && !pwrite_i
    && paddr_i == cct_pkg::ADDR_CTRL_ONE |-> prdata_o == {24'h0, c1_reg})
    else $error("control one readback wrong");
  AST_CTRL_TWO_READ: assert property (pready_o && !pwrite_i
    && paddr_i == cct_pkg::ADDR_CTRL_TWO |-> prdata_o == {24'h0, c2_reg})
    else $error("control two readback wrong");
  AST_IRQ_MASKED: assert property (global_irq_mask_i [*2] |-> !timer_irq_o)
    else $error("request while globally masked");
  AST_IRQ_NO_ENABLE: assert property ((c1_reg[7:5] == 3'h0) [*2] |-> !timer_irq_o)
    else $error("request without enable");
  AST_FORCE_ONE: assert property ((force_one && $stable(c1_reg)) [*4]
    |-> !compare_pin_one_oe_n_o && compare_pin_one_o == c1_reg[0])
    else $error("forced level one missing");
  AST_FORCE_TWO: assert property ((force_two && $stable(c1_reg)) [*4]
    |-> !compare_pin_two_oe_n_o && compare_pin_two_o == c1_reg[2])
    else $error("forced level two missing");
  AST_PIN_ONE_OFF: assert property ((!c2_reg[7]) [*3] |-> compare_pin_one_oe_n_o)
    else $error("pin one driven while disabled");
  AST_PIN_TWO_OFF: assert property ((!c2_reg[6]) [*3] |-> compare_pin_two_oe_n_o)
    else $error("pin two driven while disabled");
endmodule

bind cct_timer cct_timer_chk #(.HAS_EXT_CLOCK_PIN(HAS_EXT_CLOCK_PIN)) cct_timer_chk_i (.*);

// ### sim/tb_cct_timer.sv
// Self-checking bench for the capture/compare timer control logic
`timescale 1ns/10ps
module tb_cct_timer;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic halt_i = 1'b0;
  logic global_irq_mask_i = 1'b0;
  logic capture_pin_one_i = 1'b0;
  logic capture_pin_two_i = 1'b0;
  logic ext_clock_pin_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, compare_pin_one_o, compare_pin_one_oe_n_o;
  logic compare_pin_two_o, compare_pin_two_oe_n_o, timer_irq_o;
  int bad_count = 0;
  int check_count = 0;
  int edges;
  logic [31:0] rd, a, b;
  logic [15:0] d16;
  logic [4:0] snap;
  logic p;
  logic [1:0] codes [3] = '{cct_pkg::CLK_DIV4, cct_pkg::CLK_DIV2, cct_pkg::CLK_DIV8};
  int divs [3] = '{4, 2, 8};

  always #12.5 clk_sys_i = ~clk_sys_i;

  cct_timer cct_timer_i (.*);

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic exp, input logic got);
    chk_reg(what, {31'h0, exp}, {31'h0, got});
  endtask

  // One transfer, sampled at rising edges; an idle edge follows
  task automatic apb(input logic w, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rdat);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= adr;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    ok = (pready_o === 1'b1);
    rdat = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
    if (!ok) chk_pin("bus answer", 1'b1, 1'b0);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    apb(1'b1, adr, d, unused);
  endtask

  task automatic rd_reg(input logic [7:0] adr, output logic [31:0] d);
    apb(1'b0, adr, 32'h0, d);
  endtask

  // Samples {irq, pin one, oe one, pin two, oe two} mid-cycle, returns on an edge
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    snap = {timer_irq_o, compare_pin_one_o, compare_pin_one_oe_n_o, compare_pin_two_o,
            compare_pin_two_oe_n_o};
    @(posedge clk_sys_i);
  endtask

  task automatic set_cap(input int k, input logic v);
    if (k == 0) capture_pin_one_i <= v;
    else capture_pin_two_i <= v;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_reg(cct_pkg::ADDR_CTRL_ONE, rd);
    chk_reg("ctrl one reset", {24'h0, cct_pkg::CTRL_RESET}, rd);
    rd_reg(cct_pkg::ADDR_CTRL_TWO, rd);
    chk_reg("ctrl two reset", {24'h0, cct_pkg::CTRL_RESET}, rd);
    wr(cct_pkg::ADDR_CTRL_ONE, 32'h0000_00a6);
    rd_reg(cct_pkg::ADDR_CTRL_ONE, rd);
    chk_reg("ctrl one readback", 32'h0000_00a6, rd);
    wr(8'h40, 32'hffff_ffff);
    rd_reg(8'h40, rd);
    chk_reg("unmapped read", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(cct_pkg::ADDR_CTRL_TWO, {28'h0, codes[i], 2'h0});
      rd_reg(cct_pkg::ADDR_COUNTER, a);
      repeat (60) @(posedge clk_sys_i);
      rd_reg(cct_pkg::ADDR_COUNTER, b);
      d16 = b[15:0] - a[15:0];
      chk_reg("ticks in 64 cycles", 32'(64 / divs[i]), {16'h0, d16});
    end
    // Pin ends high: one more rising than falling edge
    for (int e = 0; e < 2; e++) begin
      wr(cct_pkg::ADDR_CTRL_TWO, {28'h0, cct_pkg::CLK_EXT, 1'b0, e[0]});
      rd_reg(cct_pkg::ADDR_COUNTER, a);
      repeat (11) begin
        ext_clock_pin_i <= ~ext_clock_pin_i;
        repeat (4) @(posedge clk_sys_i);
      end
      rd_reg(cct_pkg::ADDR_COUNTER, b);
      d16 = b[15:0] - a[15:0];
      chk_reg("external ticks", e ? 32'h6 : 32'h5, {16'h0, d16});
      ext_clock_pin_i <= 1'b0;
    end
    $display("test clock select done");
    wr(cct_pkg::ADDR_CTRL_TWO, 32'h04);
    wr(cct_pkg::ADDR_CTRL_ONE, 32'h02);
    halt_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_reg(cct_pkg::ADDR_COUNTER, a);
    capture_pin_one_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rd_reg(cct_pkg::ADDR_COUNTER, b);
    chk_reg("count held in halt", a, b);
    halt_i <= 1'b0;
    @(posedge clk_sys_i);
    rd_reg(cct_pkg::ADDR_STATUS, rd);
    chk_pin("capture one flag at exit", 1'b1, rd[cct_pkg::ST_CAPTURE_ONE_FLAG]);
    rd_reg(cct_pkg::ADDR_CAPTURE_ONE, rd);
    chk_reg("count captured at exit", b, rd);
    rd_reg(cct_pkg::ADDR_COUNTER, rd);
    d16 = rd[15:0] - b[15:0];
    chk_pin("count resumes", 1'b1, d16 inside {[16'd1:16'd8]});
    $display("test halt done");
    wr(cct_pkg::ADDR_CTRL_ONE, 32'h80);
    for (int k = 0; k < 2; k++) begin
      set_cap(k, 1'b1);
      look(8);
      chk_pin("no capture on rising", 1'b0, snap[4]);
      set_cap(k, 1'b0);
      look(8);
      chk_pin("capture request", 1'b1, snap[4]);
      rd_reg(cct_pkg::ADDR_STATUS, rd);
      chk_pin("capture flag", 1'b1, rd[k ? 4 : 7]);
      rd_reg(k ? cct_pkg::ADDR_CAPTURE_TWO : cct_pkg::ADDR_CAPTURE_ONE, rd);
      look(2);
      chk_pin("capture request cleared", 1'b0, snap[4]);
    end
    wr(cct_pkg::ADDR_CTRL_ONE, 32'h20);
    wr(cct_pkg::ADDR_COUNTER, 32'h0);
    look(20);
    chk_pin("overflow request", 1'b1, snap[4]);
    global_irq_mask_i <= 1'b1;
    look(3);
    chk_pin("masked request", 1'b0, snap[4]);
    global_irq_mask_i <= 1'b0;
    rd_reg(cct_pkg::ADDR_STATUS, rd);
    chk_pin("overflow flag", 1'b1, rd[cct_pkg::ST_OVERFLOW_FLAG]);
    rd_reg(cct_pkg::ADDR_ALT_COUNTER, rd);
    look(2);
    chk_pin("alternate keeps flag", 1'b1, snap[4]);
    rd_reg(cct_pkg::ADDR_COUNTER, rd);
    look(2);
    chk_pin("overflow cleared", 1'b0, snap[4]);
    $display("test interrupts done");
    wr(cct_pkg::ADDR_CTRL_TWO, 32'hc4);
    for (int k = 0; k < 2; k++) begin
      wr(cct_pkg::ADDR_CTRL_ONE, k ? 32'h1c : 32'h19);
      look(4);
      chk_reg("forced pins", {28'h0, ~k[0], 1'b0, k[0], 1'b0}, {28'h0, snap[3:0]});
    end
    wr(cct_pkg::ADDR_CTRL_ONE, 32'h41);
    wr(cct_pkg::ADDR_COMPARE_ONE, 32'h10);
    wr(cct_pkg::ADDR_COUNTER, 32'h0);
    look(2);
    chk_pin("no level before match", 1'b0, snap[3]);
    look(60);
    chk_reg("compare level and request", 32'h3, {30'h0, snap[4:3]});
    rd_reg(cct_pkg::ADDR_STATUS, rd);
    chk_pin("compare one flag", 1'b1, rd[cct_pkg::ST_COMPARE_ONE_FLAG]);
    rd_reg(cct_pkg::ADDR_COMPARE_ONE, rd);
    look(2);
    chk_pin("compare request cleared", 1'b0, snap[4]);
    wr(cct_pkg::ADDR_CTRL_TWO, 32'h04);
    look(4);
    chk_reg("pins released", 32'h3, {30'h0, snap[2], snap[0]});
    $display("test outputs done");
    wr(cct_pkg::ADDR_COMPARE_ONE, 32'h4);
    wr(cct_pkg::ADDR_COMPARE_TWO, 32'h10);
    wr(cct_pkg::ADDR_CTRL_ONE, 32'h04);
    wr(cct_pkg::ADDR_CTRL_TWO, 32'h94);
    wr(cct_pkg::ADDR_COUNTER, 32'h0);
    edges = 0;
    p = 1'b0;
    repeat (200) begin
      look(0);
      if (snap[3] !== p) edges++;
      p = snap[3];
    end
    chk_pin("pwm waveform", 1'b1, edges >= 6);
    rd_reg(cct_pkg::ADDR_STATUS, rd);
    chk_reg("pwm flags", 32'h4, {29'h0, rd[7], rd[6], rd[3]});
    $display("test pwm done");
    final_report();
  end
endmodule
